// *** src/dos_dir_sup.sv ***
// The address map and the Avalon-MM register port were left to the implementer.
module dos_dir_sup import dos_pkg::*; #(
  parameter int MEM_HOLD = MEM_HOLD_CYC,
  parameter int SWING = SWING_CYC,
  parameter int FLASH = FLASH_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire dos_meas_t i_meas,
  input wire logic [EL_N0-1:0][NPH-1:0] i_ph_pickup,
  input wire logic [NELEM-EL_N0-1:0] i_ng_pickup,
  input wire logic [NELEM-1:0] i_blk,
  input wire logic i_blk_neut,
  input wire logic i_blk_gnd,
  input wire logic i_panel_reset,
  output logic [NELEM-1:0] o_operate,
  output logic o_alarm_led,
  output logic [NAUX-1:0] o_aux
);
  localparam int TW = $clog2(MEM_HOLD + 1);
  localparam int SW = $clog2(SWING + 1);
  localparam int FW = $clog2(FLASH + 1);

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic [40:0] mag2(input logic signed [19:0] re, input logic signed [19:0] im);
    return 41'(re * re) + 41'(im * im);
  endfunction

  function automatic logic signed [40:0] dot(input logic signed [19:0] ar, input logic signed [19:0] ai,
                                             input logic signed [19:0] br, input logic signed [19:0] bi);
    return 41'(ar * br) + 41'(ai * bi);
  endfunction

  function automatic logic pick_rev(input dos_pol_t m, input logic vok, input logic iok,
                                    input logic vf, input logic cf);
    case (m)
      POL_VOLT: return vok & ~vf;
      POL_CURR: return iok & ~cf;
      default: return vok ? ~vf : (iok & ~cf);
    endcase
  endfunction

  dos_ctrl_t ctrl_r;
  logic [8:0] mta_r [3];
  logic [15:0] vmin_ph_r, vmin_n_r, vnom_r, ctnom_r;
  logic [2*NELEM-1:0] edir_r;
  logic [NAUX-1:0] aux_sel_r, aux_lat_r, aux_hold_r;
  logic [NPH-1:0] ph_rev_r, ph_nov_r;
  logic n_rev_r, g_rev_r, alarm_lat_r, flash_r;
  logic wait_r, req, wr_acc, prs1_r, prs2_r;
  logic [31:0] rd_mux, wval;
  dos_state_t st_r;
  dos_meas_t m_r;
  logic [2:0] vi_r;
  logic [3:0] it_r;
  logic signed [19:0] cx_r, cy_r;
  logic signed [16:0] cz_r;
  logic [4:0] fwd_r;

  // avalon slave: one wait cycle, then answer
  assign req = i_avs_read | i_avs_write;
  assign wr_acc = i_avs_write & ~wait_r;
  assign wval = merge(rd_mux, i_avs_writedata, i_avs_byteenable);

  always_comb begin
    case (i_avs_address)
      REG_CTRL: rd_mux = 32'(ctrl_r);
      REG_MTA_PH: rd_mux = 32'(mta_r[0]);
      REG_MTA_N: rd_mux = 32'(mta_r[1]);
      REG_MTA_G: rd_mux = 32'(mta_r[2]);
      REG_VMIN_PH: rd_mux = 32'(vmin_ph_r);
      REG_VMIN_N: rd_mux = 32'(vmin_n_r);
      REG_VNOM: rd_mux = 32'(vnom_r);
      REG_CTNOM: rd_mux = 32'(ctnom_r);
      REG_EDIR: rd_mux = 32'(edir_r);
      REG_AUX: rd_mux = 32'({aux_lat_r, 3'h0, aux_sel_r});
      REG_STAT: rd_mux = 32'({st_r != S_IDLE, alarm_lat_r, g_rev_r, n_rev_r, ph_nov_r, ph_rev_r});
      REG_OPER: rd_mux = 32'({o_aux, o_operate});
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wait_r <= 1'b1;
      o_avs_readdata <= '0;
    end else begin
      wait_r <= ~(req & wait_r);
      if (req & wait_r) o_avs_readdata <= i_avs_read ? rd_mux : '0;
    end
  end
  assign o_avs_waitrequest = wait_r;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl_r <= CTRL_RST;
      mta_r[0] <= MTA_PH_RST;
      mta_r[1] <= MTA_GN_RST;
      mta_r[2] <= MTA_GN_RST;
      vmin_ph_r <= VMIN_PH_RST;
      vmin_n_r <= VMIN_N_RST;
      vnom_r <= VNOM_RST;
      ctnom_r <= CTNOM_RST;
      edir_r <= '0;
      aux_sel_r <= '0;
      aux_lat_r <= '0;
    end else if (wr_acc) begin
      case (i_avs_address)
        REG_CTRL: ctrl_r <= dos_ctrl_t'(wval[8:0]);
        // out-of-range angles are ignored, register keeps old value
        REG_MTA_PH: if (wval[8:0] <= DEG_MAX) mta_r[0] <= wval[8:0];
        REG_MTA_N: if (wval[8:0] <= DEG_MAX) mta_r[1] <= wval[8:0];
        REG_MTA_G: if (wval[8:0] <= DEG_MAX) mta_r[2] <= wval[8:0];
        REG_VMIN_PH: vmin_ph_r <= wval[15:0];
        REG_VMIN_N: vmin_n_r <= wval[15:0];
        REG_VNOM: vnom_r <= wval[15:0];
        REG_CTNOM: ctnom_r <= wval[15:0];
        REG_EDIR: edir_r <= wval[2*NELEM-1:0];
        REG_AUX: begin
          aux_sel_r <= wval[NAUX-1:0];
          aux_lat_r <= wval[NAUX+7:8];
        end
        default: ;
      endcase
    end
  end

  // thresholds, squared so no root is needed
  logic [31:0] thr_ph, thr_n, thr_i;
  logic [63:0] thr2_ph, thr2_n, thr2_i;
  always_comb begin
    thr_ph = (vmin_ph_r * vnom_r) >> FRAC;
    if (ctrl_r.wye) thr_ph = (thr_ph * 32'(SQRT3_Q12)) >> FRAC;
    thr2_ph = 64'(thr_ph) * 64'(thr_ph);
    thr_n = 32'(V0_SCALE) * ((vmin_n_r * vnom_r) >> FRAC);
    thr2_n = 64'(thr_n) * 64'(thr_n);
    thr_i = (ctnom_r * CT_POL_PCT) / 32'(PCT_DEN);
    thr2_i = 64'(thr_i) * 64'(thr_i);
  end

  // zero sequence terms, left at 3x scale; scale is matched in thr_n
  logic signed [17:0] v0n_re, v0n_im, is_re, is_im;
  assign v0n_re = -(18'(m_r.v[0].re) + 18'(m_r.v[1].re) + 18'(m_r.v[2].re));
  assign v0n_im = -(18'(m_r.v[0].im) + 18'(m_r.v[1].im) + 18'(m_r.v[2].im));
  assign is_re = 18'(m_r.i[0].re) + 18'(m_r.i[1].re) + 18'(m_r.i[2].re);
  assign is_im = 18'(m_r.i[0].im) + 18'(m_r.i[1].im) + 18'(m_r.i[2].im);

  logic v0_ok, ig_ok, ip_ok, cn_fwd, cg_fwd;
  assign v0_ok = ctrl_r.wye && 64'(mag2(20'(v0n_re), 20'(v0n_im))) >= thr2_n;
  assign ig_ok = 64'(mag2(20'(m_r.ig.re), 20'(m_r.ig.im))) >= thr2_i;
  assign ip_ok = 64'(mag2(20'(m_r.ipol.re), 20'(m_r.ipol.im))) >= thr2_i;
  assign cn_fwd = dot(20'(is_re), 20'(is_im), 20'(m_r.ig.re), 20'(m_r.ig.im)) >= 0;
  assign cg_fwd = dot(20'(m_r.ig.re), 20'(m_r.ig.im), 20'(m_r.ipol.re), 20'(m_r.ipol.im)) >= 0;

  // per phase polarizing voltage and its memory
  logic signed [17:0] ll_re [NPH], ll_im [NPH], mem_re [NPH], mem_im [NPH];
  logic [TW-1:0] tmr [NPH];
  logic [NPH-1:0] ph_hl, vok;
  for (genvar k = 0; k < NPH; k++) begin : g_ph
    localparam int KB = (k + 1) % NPH;
    localparam int KC = (k + 2) % NPH;
    logic signed [17:0] lr, li;
    // wye: build the line voltage; delta channels already are line voltages
    assign lr = ctrl_r.wye ? 18'(m_r.v[KB].re) - 18'(m_r.v[KC].re) : 18'(m_r.v[KB].re);
    assign li = ctrl_r.wye ? 18'(m_r.v[KB].im) - 18'(m_r.v[KC].im) : 18'(m_r.v[KB].im);
    assign ll_re[k] = ctrl_r.acb ? -lr : lr;
    assign ll_im[k] = ctrl_r.acb ? -li : li;
    assign ph_hl[k] = 64'(mag2(20'(ll_re[k]), 20'(ll_im[k]))) >= thr2_ph;
    assign vok[k] = ph_hl[k] | (tmr[k] != '0);
    always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
        mem_re[k] <= '0;
        mem_im[k] <= '0;
        tmr[k] <= '0;
      end else if (st_r == S_DEC && ph_hl[k]) begin
        mem_re[k] <= ll_re[k];
        mem_im[k] <= ll_im[k];
        tmr[k] <= TW'(MEM_HOLD);
      end else if (tmr[k] != '0) begin
        tmr[k] <= tmr[k] - 1'b1;
      end
    end
  end

  // one shared cordic rotates each polarizing vector by its torque angle
  logic signed [17:0] p_re, p_im, o_re, o_im;
  logic [8:0] max_torque_angle, resid;
  logic [1:0] quad;
  always_comb begin
    if (vi_r < VI_N) begin
      p_re = ph_hl[vi_r[1:0]] ? ll_re[vi_r[1:0]] : mem_re[vi_r[1:0]];
      p_im = ph_hl[vi_r[1:0]] ? ll_im[vi_r[1:0]] : mem_im[vi_r[1:0]];
      o_re = 18'(m_r.i[vi_r[1:0]].re);
      o_im = 18'(m_r.i[vi_r[1:0]].im);
      max_torque_angle = mta_r[0];
    end else begin
      p_re = v0n_re;
      p_im = v0n_im;
      o_re = (vi_r == VI_N) ? is_re : 18'(m_r.ig.re);
      o_im = (vi_r == VI_N) ? is_im : 18'(m_r.ig.im);
      max_torque_angle = (vi_r == VI_N) ? mta_r[1] : mta_r[2];
    end
    if (max_torque_angle >= DEG_270) begin
      quad = 2'h3;
      resid = max_torque_angle - DEG_270;
    end else if (max_torque_angle >= DEG_180) begin
      quad = 2'h2;
      resid = max_torque_angle - DEG_180;
    end else if (max_torque_angle >= DEG_90) begin
      quad = 2'h1;
      resid = max_torque_angle - DEG_90;
    end else begin
      quad = 2'h0;
      resid = max_torque_angle;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_r <= S_IDLE;
      m_r <= '0;
      vi_r <= '0;
      it_r <= '0;
      cx_r <= '0;
      cy_r <= '0;
      cz_r <= '0;
      fwd_r <= '0;
    end else begin
      case (st_r)
        S_IDLE: if (i_meas.valid) begin
          m_r <= i_meas;
          vi_r <= '0;
          st_r <= S_LOAD;
        end
        S_LOAD: begin
          case (quad)
            2'h1: begin cx_r <= -20'(p_im); cy_r <= 20'(p_re); end
            2'h2: begin cx_r <= -20'(p_re); cy_r <= -20'(p_im); end
            2'h3: begin cx_r <= 20'(p_im); cy_r <= -20'(p_re); end
            default: begin cx_r <= 20'(p_re); cy_r <= 20'(p_im); end
          endcase
          cz_r <= 17'({resid[6:0], 8'h00});
          it_r <= '0;
          st_r <= S_ROT;
        end
        S_ROT: begin
          if (!cz_r[16]) begin
            cx_r <= cx_r - (cy_r >>> it_r);
            cy_r <= cy_r + (cx_r >>> it_r);
            cz_r <= cz_r - 17'(ATAN_Q8[it_r]);
          end else begin
            cx_r <= cx_r + (cy_r >>> it_r);
            cy_r <= cy_r - (cx_r >>> it_r);
            cz_r <= cz_r + 17'(ATAN_Q8[it_r]);
          end
          it_r <= it_r + 1'b1;
          if (it_r == 4'(CORDIC_ITER - 1)) st_r <= S_DOT;
        end
        S_DOT: begin
          // forward when operating current within 90 deg of rotated reference
          fwd_r[vi_r] <= dot(20'(o_re), 20'(o_im), cx_r, cy_r) >= 0;
          vi_r <= vi_r + 1'b1;
          st_r <= (vi_r == VI_G) ? S_DEC : S_LOAD;
        end
        S_DEC: st_r <= S_IDLE;
        default: st_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ph_rev_r <= '0;
      ph_nov_r <= '0;
      n_rev_r <= 1'b0;
      g_rev_r <= 1'b0;
    end else if (st_r == S_DEC) begin
      ph_rev_r <= vok & ~fwd_r[NPH-1:0];
      ph_nov_r <= ~vok;
      n_rev_r <= pick_rev(ctrl_r.npol, v0_ok, ig_ok, fwd_r[VI_N], cn_fwd);
      g_rev_r <= pick_rev(ctrl_r.gpol, v0_ok, ip_ok, fwd_r[VI_G], cg_fwd);
    end
  end

  // element gating
  for (genvar e = 0; e < NELEM; e++) begin : g_el
    dos_edir_t want;
    logic ctl, ok, pick, blk;
    logic [SW-1:0] cnt;
    assign want = dos_edir_t'(edir_r[2*e +: 2]);
    if (e < EL_N0) begin : g_p
      logic [NPH-1:0] match, okp;
      assign pick = |i_ph_pickup[e];
      assign ctl = want != ED_DIS && ctrl_r.func != FN_DIS;
      assign match = (want == ED_REV) ? ph_rev_r : ~ph_rev_r;
      // no voltage and no memory: block or pass per the expiry setting
      assign okp = (ph_nov_r & {NPH{~ctrl_r.blk_mem}}) | (~ph_nov_r & match);
      assign ok = |(i_ph_pickup[e] & okp);
      assign blk = i_blk[e];
    end else begin : g_n
      logic rev;
      assign rev = (e < EL_G0) ? n_rev_r : g_rev_r;
      assign pick = i_ng_pickup[e-EL_N0];
      assign ctl = want != ED_DIS;
      assign ok = pick & ((want == ED_REV) == rev);
      assign blk = i_blk[e] | ((e < EL_G0) ? i_blk_neut : i_blk_gnd);
    end
    always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || !(ctl && ok)) cnt <= '0;
      else if (cnt != SW'(SWING)) cnt <= cnt + 1'b1;
    end
    always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) o_operate[e] <= 1'b0;
      else o_operate[e] <= ~blk & (ctl ? (cnt == SW'(SWING)) : pick);
    end
  end

  // panel reset is a pin
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      prs1_r <= 1'b0;
      prs2_r <= 1'b0;
    end else begin
      prs1_r <= i_panel_reset;
      prs2_r <= prs1_r;
    end
  end

  logic [FW-1:0] fcnt;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      fcnt <= '0;
      flash_r <= 1'b0;
    end else if (fcnt == FW'(FLASH - 1)) begin
      fcnt <= '0;
      flash_r <= ~flash_r;
    end else begin
      fcnt <= fcnt + 1'b1;
    end
  end

  logic rev_any, dir_on;
  assign rev_any = |ph_rev_r;
  assign dir_on = ctrl_r.func != FN_DIS;
  // set wins over a reset press held during reverse
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      alarm_lat_r <= 1'b0;
      o_alarm_led <= 1'b0;
      aux_hold_r <= '0;
      o_aux <= '0;
    end else begin
      alarm_lat_r <= (ctrl_r.func == FN_LATCH && rev_any) | (alarm_lat_r & ~prs2_r);
      case (ctrl_r.func)
        FN_ALARM: o_alarm_led <= rev_any & flash_r;
        FN_LATCH: o_alarm_led <= rev_any ? flash_r : alarm_lat_r;
        default: o_alarm_led <= 1'b0;
      endcase
      aux_hold_r <= (aux_sel_r & aux_lat_r & {NAUX{rev_any & dir_on}}) | (aux_hold_r & ~{NAUX{prs2_r}});
      o_aux <= (aux_sel_r & {NAUX{rev_any & dir_on}}) | aux_hold_r;
    end
  end
endmodule

// *** src/dos_pkg.sv ***
package dos_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MEM_HOLD_MS = 1000;
  localparam int MEM_HOLD_CYC = MEM_HOLD_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int PWR_HZ = 60;
  localparam int SWING_DEN = PWR_HZ * CLK_PERIOD_NS;
  localparam int SWING_CYC = (1_000_000_000 + SWING_DEN - 1) / SWING_DEN;
  localparam int FLASH_MS = 250;
  localparam int FLASH_CYC = FLASH_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int NELEM = 9;
  localparam int EL_N0 = 3;
  localparam int EL_G0 = 7;
  localparam int NPH = 3;
  localparam int NAUX = 5;
  localparam int CORDIC_ITER = 12;
  localparam int FRAC = 12;
  localparam int V0_SCALE = 3;
  localparam logic [2:0] VI_N = 3'h3;
  localparam logic [2:0] VI_G = 3'h4;
  localparam logic [15:0] SQRT3_Q12 = 16'h1bb6;
  localparam logic [15:0] CT_POL_PCT = 16'h0005;
  localparam logic [15:0] PCT_DEN = 16'h0064;
  localparam logic [8:0] DEG_90 = 9'h05a;
  localparam logic [8:0] DEG_180 = 9'h0b4;
  localparam logic [8:0] DEG_270 = 9'h10e;
  localparam logic [8:0] DEG_MAX = 9'h167;
  localparam logic [15:0] ATAN_Q8 [CORDIC_ITER] = '{16'h2d00, 16'h1a91, 16'h0e09, 16'h0720,
    16'h0393, 16'h01ca, 16'h00e5, 16'h0073, 16'h0039, 16'h001d, 16'h000e, 16'h0007};
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_MTA_PH = 6'h04;
  localparam logic [5:0] REG_MTA_N = 6'h08;
  localparam logic [5:0] REG_MTA_G = 6'h0c;
  localparam logic [5:0] REG_VMIN_PH = 6'h10;
  localparam logic [5:0] REG_VMIN_N = 6'h14;
  localparam logic [5:0] REG_VNOM = 6'h18;
  localparam logic [5:0] REG_CTNOM = 6'h1c;
  localparam logic [5:0] REG_EDIR = 6'h20;
  localparam logic [5:0] REG_AUX = 6'h24;
  localparam logic [5:0] REG_STAT = 6'h28;
  localparam logic [5:0] REG_OPER = 6'h2c;
  localparam logic [8:0] MTA_PH_RST = 9'h01e;
  localparam logic [8:0] MTA_GN_RST = 9'h000;
  localparam logic [15:0] VMIN_PH_RST = 16'h0800;
  localparam logic [15:0] VMIN_N_RST = 16'h00cd;
  localparam logic [15:0] VNOM_RST = 16'h1000;
  localparam logic [15:0] CTNOM_RST = 16'h1000;
  typedef enum logic [1:0] {FN_DIS, FN_CTRL, FN_ALARM, FN_LATCH} dos_func_t;
  typedef enum logic [1:0] {POL_DUAL, POL_VOLT, POL_CURR} dos_pol_t;
  typedef enum logic [1:0] {ED_DIS, ED_FWD, ED_REV} dos_edir_t;
  typedef enum logic [2:0] {S_IDLE, S_LOAD, S_ROT, S_DOT, S_DEC} dos_state_t;
  typedef struct packed {
    dos_pol_t gpol;
    dos_pol_t npol;
    logic acb;
    logic wye;
    logic blk_mem;
    dos_func_t func;
  } dos_ctrl_t;
  localparam dos_ctrl_t CTRL_RST = '{POL_DUAL, POL_DUAL, 1'b0, 1'b1, 1'b0, FN_DIS};
  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } dos_phasor_t;
  typedef struct packed {
    logic valid;
    dos_phasor_t [NPH-1:0] v;
    dos_phasor_t [NPH-1:0] i;
    dos_phasor_t ig;
    dos_phasor_t ipol;
  } dos_meas_t;
endpackage

// *** tb/dos_dir_sup_props.sv ***
module dos_dir_sup_props import dos_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [EL_N0-1:0][NPH-1:0] i_ph_pickup,
  input wire logic [NELEM-EL_N0-1:0] i_ng_pickup,
  input wire logic [NELEM-1:0] i_blk,
  input wire logic i_blk_neut,
  input wire logic i_blk_gnd,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [NELEM-1:0] o_operate,
  input wire logic o_alarm_led,
  input wire logic [NAUX-1:0] o_aux
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  property p_wait_one;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("request not answered next cycle");
  property p_wait_rel;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_wait_rel: assert property (p_wait_rel) else $error("waitrequest low too long");
  property p_wait_idle;
    !(i_avs_read || i_avs_write) && o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
  // past reset guard: a one-edge reset leaves the old value in the history
  property p_rd_hold;
    o_avs_waitrequest && $past(o_avs_waitrequest) && $past(i_rst_n) |-> $stable(o_avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved between accesses");
  property p_unmapped;
    !o_avs_waitrequest && i_avs_read && (i_avs_address > 6'h2c) |-> o_avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rst;
    disable iff (1'b0) !i_rst_n |=> o_operate == '0 && !o_alarm_led && o_aux == '0 && o_avs_waitrequest;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared in reset");
  property p_blk;
    |i_blk ##1 |i_blk |=> (o_operate & $past(i_blk, 2) & $past(i_blk)) == '0;
  endproperty
  a_blk: assert property (p_blk) else $error("blocked element operated");
  property p_blk_neut;
    i_blk_neut [*2] |=> o_operate[6:3] == 4'h0;
  endproperty
  a_blk_neut: assert property (p_blk_neut) else $error("neutral group block ignored");
  property p_blk_gnd;
    i_blk_gnd [*2] |=> o_operate[8:7] == 2'h0;
  endproperty
  a_blk_gnd: assert property (p_blk_gnd) else $error("ground group block ignored");
  property p_nopick_ng;
    (i_ng_pickup == '0) [*2] |=> o_operate[8:3] == 6'h0;
  endproperty
  a_nopick_ng: assert property (p_nopick_ng) else $error("neutral or ground operated without pickup");
  property p_nopick_ph;
    (i_ph_pickup == '0) [*2] |=> o_operate[2:0] == 3'h0;
  endproperty
  a_nopick_ph: assert property (p_nopick_ph) else $error("phase operated without pickup");
endmodule

bind dos_dir_sup dos_dir_sup_props i_dos_dir_sup_props (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_ph_pickup(i_ph_pickup), .i_ng_pickup(i_ng_pickup), .i_blk(i_blk), .i_blk_neut(i_blk_neut),
  .i_blk_gnd(i_blk_gnd), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_operate(o_operate), .o_alarm_led(o_alarm_led), .o_aux(o_aux));

// *** tb/dos_oc_model.sv ***
// far side: overcurrent pickups and output contacts
module dos_oc_model import dos_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic [NPH-1:0] i_ph_fault,
  input wire logic [NELEM-EL_N0-1:0] i_ng_fault,
  input wire logic [NAUX-1:0] i_aux,
  output logic [EL_N0-1:0][NPH-1:0] o_ph_pickup,
  output logic [NELEM-EL_N0-1:0] o_ng_pickup,
  output logic [NAUX-1:0] o_contact
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_ph_pickup = '0;
    o_ng_pickup = '0;
    o_contact = '0;
  end
  // every phase element picks up on the same faulted phases
  always @(posedge i_sys_clk) begin
    o_ph_pickup <= {EL_N0{i_ph_fault}};
    o_ng_pickup <= i_ng_fault;
    o_contact <= i_aux;
  end
endmodule

// *** tb/test_dos_dir_sup.sv ***
module test_dos_dir_sup import dos_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, blk_neut = 1'b0, blk_gnd = 1'b0, panel = 1'b0;
  logic [5:0] addr = '0;
  logic [31:0] wdata = '0, rdata, q;
  logic wreq, led;
  logic [1:0] fl;
  logic [NELEM-1:0] blk = '0, operate;
  logic [NAUX-1:0] aux, contact;
  logic [NPH-1:0] ph_fault = '0;
  logic [NELEM-EL_N0-1:0] ng_fault = '0, ng_pick;
  logic [EL_N0-1:0][NPH-1:0] ph_pick;
  dos_meas_t meas = '0;
  int mismatches = 0, checked = 0;
  logic [5:0] ra [9] = '{REG_CTRL, REG_MTA_PH, REG_MTA_N, REG_MTA_G, REG_VMIN_PH, REG_VMIN_N, REG_VNOM,
    REG_CTNOM, 6'h30};
  logic [31:0] rv [9] = '{32'h008, 32'h01e, 32'h0, 32'h0, 32'h800, 32'h0cd, 32'h1000, 32'h1000, 32'h0};
  always #12.5 clk = ~clk;
  // short counts so the run stays brief; memory outlives the measurement spacing
  dos_dir_sup #(.MEM_HOLD(400), .SWING(8), .FLASH(4)) i_dos_dir_sup (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_meas(meas),
    .i_ph_pickup(ph_pick), .i_ng_pickup(ng_pick), .i_blk(blk), .i_blk_neut(blk_neut), .i_blk_gnd(blk_gnd),
    .i_panel_reset(panel), .o_operate(operate), .o_alarm_led(led), .o_aux(aux));
  dos_oc_model i_dos_oc_model (.i_sys_clk(clk), .i_ph_fault(ph_fault), .i_ng_fault(ng_fault), .i_aux(aux),
    .o_ph_pickup(ph_pick), .o_ng_pickup(ng_pick), .o_contact(contact));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // hold the request to the rising edge that samples waitrequest low; only the watchdog ends a hang
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(nm, q & m, e);
  endtask
  function automatic dos_phasor_t pha(input int re, input int im);
    pha = {re[15:0], im[15:0]};
  endfunction
  // balanced wye volts scaled by vs; s=1 puts every current more than 90 deg from its quadrature reference
  task automatic meas_go(input int s, input int ip, input int vs);
    @(posedge clk);
    meas.valid <= 1'b1;
    meas.v <= {pha(-2000 * vs, 3464 * vs), pha(-2000 * vs, -3464 * vs), pha(4000 * vs, 0)};
    meas.i <= {pha(-3000 * s, 1732 * s), pha(3000 * s, -1732 * s), pha(500 * s, 3000 * s)};
    // ground input polarizes the neutral; the separate polarizing input serves only the ground
    meas.ig <= pha(ip, 0);
    meas.ipol <= pha(0, 0);
    @(posedge clk);
    meas.valid <= 1'b0;
    repeat (80) @(posedge clk);
  endtask
  task automatic panel_pulse;
    @(posedge clk);
    panel <= 1'b1;
    repeat (2) @(posedge clk);
    panel <= 1'b0;
    repeat (6) @(negedge clk);
  endtask
  task close_out;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    close_out;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 9; k++) rchk("reset value", ra[k], 32'hffffffff, rv[k]);
    bus(REG_MTA_PH, 1'b1, 32'h168);
    rchk("angle 360", REG_MTA_PH, 32'hffffffff, 32'h01e);
    bus(REG_MTA_PH, 1'b1, 32'h167);
    rchk("angle 359", REG_MTA_PH, 32'hffffffff, 32'h167);
    bus(REG_MTA_PH, 1'b1, 32'h0);
    ph_fault <= 3'h7;
    ng_fault <= 6'h3f;
    // pickups pass the far-side model and the output flop before the read samples them
    repeat (2) @(posedge clk);
    rchk("operate all", REG_OPER, 32'hffffffff, 32'h1ff);
    blk <= 9'h008;
    rchk("operate blk", REG_OPER, 32'hffffffff, 32'h1f7);
    blk_neut <= 1'b1;
    rchk("operate neut grp", REG_OPER, 32'hffffffff, 32'h187);
    blk_gnd <= 1'b1;
    rchk("operate gnd grp", REG_OPER, 32'hffffffff, 32'h007);
    blk <= '0;
    blk_neut <= 1'b0;
    blk_gnd <= 1'b0;
    ph_fault <= '0;
    ng_fault <= '0;
    // alarm mode, current polarized neutral, phase toc forward, neutral toc1 reverse, contacts 0 and 1, contact 0 latched
    bus(REG_CTRL, 1'b1, 32'h04a);
    bus(REG_EDIR, 1'b1, 32'h81);
    bus(REG_AUX, 1'b1, 32'h103);
    meas_go(1, -2000, 1);
    rchk("dir reverse", REG_STAT, 32'h47, 32'h47);
    ph_fault <= 3'h7;
    ng_fault <= 6'h01;
    fl = 2'b00;
    repeat (20) begin
      @(negedge clk);
      fl = fl | {led, !led};
    end
    chk("led flash", 32'(fl), 32'h3);
    chk("operate rev", 32'(operate[0]), 32'h0);
    chk("neutral rev", 32'(operate[3]), 32'h1);
    chk("aux rev", 32'(aux), 32'h03);
    chk("contact rev", 32'(contact), 32'h03);
    meas_go(-1, -2000, 1);
    rchk("dir forward", REG_STAT, 32'h47, 32'h0);
    @(negedge clk);
    chk("led off", 32'(led), 32'h0);
    chk("aux latched", 32'(aux), 32'h01);
    chk("operate fwd", 32'(operate[0]), 32'h1);
    chk("neutral fwd", 32'(operate[3]), 32'h0);
    @(posedge clk);
    ph_fault <= '0;
    repeat (4) @(posedge clk);
    ph_fault <= 3'h7;
    repeat (6) @(negedge clk);
    chk("swing early", 32'(operate[0]), 32'h0);
    repeat (10) @(negedge clk);
    chk("swing late", 32'(operate[0]), 32'h1);
    panel_pulse;
    chk("aux reset", 32'(aux), 32'h0);
    bus(REG_CTRL, 1'b1, 32'h04b);
    meas_go(1, -100, 1);
    rchk("dir weak pol", REG_STAT, 32'h47, 32'h07);
    meas_go(-1, -2000, 1);
    @(negedge clk);
    chk("led held", 32'(led), 32'h1);
    panel_pulse;
    chk("led reset", 32'(led), 32'h0);
    bus(REG_CTRL, 1'b1, 32'h048);
    meas_go(1, -2000, 1);
    chk("operate no dir", 32'(operate[0]), 32'h1);
    chk("aux no dir", 32'(aux), 32'h0);
    // control mode, block on expired memory; the voltage then collapses
    bus(REG_CTRL, 1'b1, 32'h00d);
    meas_go(1, 0, 1);
    meas_go(1, 0, 0);
    rchk("dir memory", REG_STAT, 32'h3f, 32'h07);
    repeat (400) @(posedge clk);
    meas_go(1, 0, 0);
    rchk("dir expired", REG_STAT, 32'h3f, 32'h38);
    @(negedge clk);
    chk("operate expired", 32'(operate[0]), 32'h0);
    bus(REG_CTRL, 1'b1, 32'h009);
    repeat (12) @(negedge clk);
    chk("operate no volts", 32'(operate[0]), 32'h1);
    close_out;
  end
endmodule
